// ---- hw/eeprom_read_pkg.sv ----
/*
  Constants, types and field layouts for the two-wire EEPROM read engine.
  Assumes one link master drives the serial clock and that the array is the
  larger variant with an 8-bit word address.
*/

package eeprom_read_pkg;

  // ==========================================================
  // widths and counts
  localparam int           WORD_ADDR_W  = 8;
  localparam int           SN_IDX_W     = 4;
  localparam int           SN_BITS      = 128;
  localparam int           CS_W         = 3;
  localparam logic [2:0]   BIT_LAST     = 3'h7;
  localparam logic [2:0]   BIT_FIRST    = 3'h0;

  // ==========================================================
  // address codes
  localparam logic [3:0]   TYPE_ARRAY   = 4'ha;
  localparam logic [3:0]   TYPE_SN      = 4'hb;
  localparam logic [1:0]   SN_TOP_BITS  = 2'h2;
  localparam logic [7:0]   ADDR_FIRST   = 8'h00;
  localparam logic [7:0]   ADDR_LAST    = 8'hff;
  localparam logic [7:0]   PTR_RESET    = 8'h00;
  localparam logic [3:0]   SN_IDX_LAST  = 4'hf;
  localparam logic [3:0]   SN_IDX_ONE   = 4'h1;
  localparam logic [7:0]   ADDR_ONE     = 8'h01;

  // ==========================================================
  // contents
  localparam logic [7:0]   ERASED_BYTE  = 8'hff;
  // arbitrary value, stands in for the factory serial number
  localparam logic [127:0] SN_VALUE     = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;

  // ==========================================================
  // device address byte layout
  typedef struct packed {
    logic [3:0] type_code;
    logic [2:0] cs;
    logic       rd;
  } dev_addr_type;

  // ==========================================================
  // link states
  typedef enum logic [7:0] {
    ST_IDLE      = 8'h01,
    ST_DEV       = 8'h02,
    ST_DEV_ACK   = 8'h04,
    ST_WADDR     = 8'h08,
    ST_WADDR_ACK = 8'h10,
    ST_SKIP      = 8'h20,
    ST_SEND      = 8'h40,
    ST_MACK      = 8'h80
  } state_type;

endpackage : eeprom_read_pkg

// ---- hw/bit_sync.sv ----
/*
  Two-stage level synchroniser of parameterised width.
  Assumes the input is a level held long enough for the destination clock.
*/
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         en,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // ==========================================================
  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else if (en)
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : bit_sync

`default_nettype wire

// ---- hw/eeprom_read_engine.sv ----
/*
  Read engine of a two-wire EEPROM target with a 16-byte serial number.
  Link logic runs on the master's serial clock; a status side runs on CLK.
  Assumes an open-drain data wire resolved outside and a write engine that
  reports its self-timed cycle on WRITE_BUSY in the CLK domain.
*/
`timescale 1ns/1ps
`default_nettype none

module eeprom_read_engine (
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic CLK_EN,
  input  wire logic LINK_SCL,
  input  wire logic SDA_I,
  output var  logic SDA_O,
  output var  logic SDA_OE,
  input  wire logic CHIP_SELECT_BIT_2,
  input  wire logic CHIP_SELECT_BIT_1,
  input  wire logic CHIP_SELECT_BIT_0,
  input  wire logic WRITE_BUSY,
  output var  logic BYTE_SENT,
  output var  logic READ_ACTIVE
);

  import eeprom_read_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [7:0] read_byte(input logic sn,
                                           input logic [WORD_ADDR_W-1:0] p);
    logic [SN_IDX_W-1:0] idx;
    idx = p[SN_IDX_W-1:0];
    // any top-bit pattern other than 10 is undefined; same table is used
    if (sn)
      read_byte = SN_VALUE[SN_BITS - 1 - 8 * idx -: 8];
    else
      read_byte = ERASED_BYTE;
  endfunction : read_byte

  function automatic logic [WORD_ADDR_W-1:0] next_ptr(
    input logic sn, input logic [WORD_ADDR_W-1:0] p);
    if (sn)
      next_ptr = {p[WORD_ADDR_W-1:SN_IDX_W],
                  4'(p[SN_IDX_W-1:0] + SN_IDX_ONE)};
    else if (p == ADDR_LAST)
      next_ptr = ADDR_FIRST;
    else
      next_ptr = 8'(p + ADDR_ONE);
  endfunction : next_ptr

  // ==========================================================
  // link-domain signals
  state_type                 st_q;
  logic [2:0]                cnt_q;
  logic [7:0]                rx_q;
  logic [7:0]                tx_q;
  logic [7:0]                cur_byte;
  logic [WORD_ADDR_W-1:0]    ptr_q;
  logic                      sn_q;
  logic                      rd_q;
  logic                      oe_q;
  logic                      sda_r_q;
  logic                      done_tg_q;
  logic                      active_q;
  logic [CS_W:0]             pins_s;
  logic [CS_W-1:0]           cs_s;
  logic                      busy_s;
  logic [7:0]                rx_byte;
  dev_addr_type              dev;
  logic                      match;
  logic                      start;

  // ==========================================================
  // pins into the link domain
  bit_sync #(
    .W (CS_W + 1)
  ) u_link_sync (
    .clk   (LINK_SCL),
    .rst_n (RST_N),
    .en    (1'b1),
    .d     ({WRITE_BUSY, CHIP_SELECT_BIT_2, CHIP_SELECT_BIT_1, CHIP_SELECT_BIT_0}),
    .q     (pins_s)
  );

  assign busy_s = pins_s[CS_W];
  assign cs_s   = pins_s[CS_W-1:0];

  // ==========================================================
  // data bit sampled while the clock is high
  always_ff @(posedge LINK_SCL or negedge RST_N)
  begin
    if (!RST_N)
      sda_r_q <= 1'b1;
    else
      sda_r_q <= SDA_I;
  end

  assign rx_byte = {rx_q[6:0], sda_r_q};
  assign dev     = dev_addr_type'(rx_byte);
  // type code 1010 or 1011 only
  assign match   = (dev.type_code == TYPE_ARRAY || dev.type_code == TYPE_SN)
                   && dev.cs == cs_s && !busy_s;
  // start: data fell while the clock was high; an idle bus accepts a
  // stop-then-start too, at the cost of not seeing stops on their own
  assign start   = !SDA_I && (sda_r_q || st_q == ST_IDLE);

  // ==========================================================
  // protocol state and bit counter
  always_ff @(negedge LINK_SCL or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_q  <= ST_IDLE;
      cnt_q <= BIT_FIRST;
    end
    else if (start && st_q != ST_SEND && st_q != ST_DEV_ACK
             && st_q != ST_WADDR_ACK)
    begin
      st_q  <= ST_DEV;
      cnt_q <= BIT_FIRST;
    end
    else
    begin
      unique case (st_q)
        ST_IDLE, ST_SKIP:
          st_q <= st_q;
        ST_DEV:
        begin
          cnt_q <= 3'(cnt_q + 3'h1);
          if (cnt_q == BIT_LAST)
            st_q <= match ? ST_DEV_ACK : ST_IDLE;
        end
        ST_DEV_ACK:
        begin
          cnt_q <= BIT_FIRST;
          st_q  <= rd_q ? ST_SEND : ST_WADDR;
        end
        ST_WADDR:
        begin
          cnt_q <= 3'(cnt_q + 3'h1);
          if (cnt_q == BIT_LAST)
            st_q <= ST_WADDR_ACK;
        end
        // data bytes of a write belong to the write engine
        ST_WADDR_ACK:
          st_q <= ST_SKIP;
        ST_SEND:
        begin
          cnt_q <= 3'(cnt_q + 3'h1);
          if (cnt_q == BIT_LAST)
            st_q <= ST_MACK;
        end
        ST_MACK:
        begin
          cnt_q <= BIT_FIRST;
          st_q  <= sda_r_q ? ST_IDLE : ST_SEND;
        end
      endcase
    end
  end

  // ==========================================================
  // receive shifter
  always_ff @(negedge LINK_SCL or negedge RST_N)
  begin
    if (!RST_N)
      rx_q <= 8'h00;
    else if (st_q == ST_DEV || st_q == ST_WADDR)
      rx_q <= rx_byte;
  end

  // ==========================================================
  // region and direction of the current transfer
  always_ff @(negedge LINK_SCL or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sn_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else if (st_q == ST_DEV && cnt_q == BIT_LAST && match && !start)
    begin
      sn_q <= dev.type_code == TYPE_SN;
      rd_q <= dev.rd;
    end
  end

  // ==========================================================
  // shared pointer; kept through idle, lost only at reset
  always_ff @(negedge LINK_SCL or negedge RST_N)
  begin
    if (!RST_N)
      ptr_q <= PTR_RESET;
    else if (start && st_q != ST_SEND && st_q != ST_DEV_ACK
             && st_q != ST_WADDR_ACK)
      ptr_q <= ptr_q;
    else if (st_q == ST_WADDR && cnt_q == BIT_LAST)
      ptr_q <= rx_byte;
    else if ((st_q == ST_DEV_ACK && rd_q) || (st_q == ST_MACK && !sda_r_q))
      ptr_q <= next_ptr(sn_q, ptr_q);
  end

  // ==========================================================
  // transmit shifter and data drive
  // byte at the pointer, named so its bits can be picked apart
  assign cur_byte = read_byte(sn_q, ptr_q);

  always_ff @(negedge LINK_SCL or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tx_q <= ERASED_BYTE;
      oe_q <= 1'b0;
    end
    else if (start && st_q != ST_SEND && st_q != ST_DEV_ACK
             && st_q != ST_WADDR_ACK)
      oe_q <= 1'b0;
    else if ((st_q == ST_DEV_ACK && rd_q) || (st_q == ST_MACK && !sda_r_q))
    begin
      tx_q <= {cur_byte[6:0], 1'b0};
      oe_q <= !cur_byte[7];
    end
    else if (st_q == ST_SEND && cnt_q != BIT_LAST)
    begin
      tx_q <= {tx_q[6:0], 1'b0};
      oe_q <= !tx_q[7];
    end
    else if ((st_q == ST_DEV || st_q == ST_WADDR) && cnt_q == BIT_LAST)
      oe_q <= (st_q == ST_WADDR) || match;
    else
      oe_q <= 1'b0;
  end

  // ==========================================================
  // events toward the status side
  always_ff @(negedge LINK_SCL or negedge RST_N)
  begin
    if (!RST_N)
    begin
      done_tg_q <= 1'b0;
      active_q  <= 1'b0;
    end
    else
    begin
      if (st_q == ST_SEND && cnt_q == BIT_LAST)
        done_tg_q <= !done_tg_q;
      active_q <= (st_q == ST_DEV_ACK && rd_q) || st_q == ST_SEND
                  || (st_q == ST_MACK && !sda_r_q);
    end
  end

  // ==========================================================
  // pad drive; the wire is only ever pulled low
  always_ff @(negedge LINK_SCL or negedge RST_N)
  begin
    if (!RST_N)
      SDA_O <= 1'b0;
    else
      SDA_O <= 1'b0;
  end

  assign SDA_OE = oe_q;

  // ==========================================================
  // status domain
  logic [1:0] stat_s;
  logic       tg_prev_q;

  bit_sync #(
    .W (2)
  ) u_stat_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .en    (CLK_EN),
    .d     ({active_q, done_tg_q}),
    .q     (stat_s)
  );

  // the link clock may stop mid-byte, so only levels cross; READ_ACTIVE is a level copy, BYTE_SENT an edge of the toggle
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tg_prev_q   <= 1'b0;
      BYTE_SENT   <= 1'b0;
      READ_ACTIVE <= 1'b0;
    end
    else if (CLK_EN)
    begin
      tg_prev_q   <= stat_s[0];
      BYTE_SENT   <= stat_s[0] ^ tg_prev_q;
      READ_ACTIVE <= stat_s[1];
    end
  end

  // ==========================================================
  // checks on the link side
  a_ack_on_match: assert property (@(negedge LINK_SCL) disable iff (!RST_N)
    st_q == ST_DEV && cnt_q == BIT_LAST && match && !start
    |=> oe_q && st_q == ST_DEV_ACK)
    else $error("matching address not acknowledged");

  a_nack_mismatch: assert property (@(negedge LINK_SCL) disable iff (!RST_N)
    st_q == ST_DEV && cnt_q == BIT_LAST && !match && !start
    |=> !oe_q ##1 !oe_q)
    else $error("foreign address acknowledged");

  a_busy_no_ack: assert property (@(negedge LINK_SCL) disable iff (!RST_N)
    st_q == ST_DEV && cnt_q == BIT_LAST && busy_s |=> !oe_q)
    else $error("address acknowledged during write cycle");

  a_read_dir_send: assert property (@(negedge LINK_SCL) disable iff (!RST_N)
    st_q == ST_DEV_ACK && !start |=> (st_q == ST_SEND) == $past(rd_q))
    else $error("direction bit not honoured");

  a_ptr_load: assert property (@(negedge LINK_SCL) disable iff (!RST_N)
    st_q == ST_WADDR && cnt_q == BIT_LAST && !start
    |=> ptr_q == $past(rx_byte) ##1 ptr_q == $past(rx_byte, 2))
    else $error("word address not loaded");

  a_ptr_advance: assert property (@(negedge LINK_SCL) disable iff (!RST_N)
    st_q == ST_DEV_ACK && rd_q && !sn_q && !start
    |=> ptr_q == 8'($past(ptr_q) + ADDR_ONE))
    else $error("pointer not advanced past read byte");

  a_array_wrap: assert property (@(negedge LINK_SCL) disable iff (!RST_N)
    st_q == ST_MACK && !sda_r_q && !sn_q && ptr_q == ADDR_LAST && !start
    |=> ptr_q == ADDR_FIRST)
    else $error("array pointer did not wrap");

  a_sn_wrap: assert property (@(negedge LINK_SCL) disable iff (!RST_N)
    st_q == ST_MACK && !sda_r_q && sn_q && ptr_q[3:0] == SN_IDX_LAST && !start
    |=> ptr_q[3:0] == 4'h0 && ptr_q[7:4] == $past(ptr_q[7:4]))
    else $error("serial pointer left its block");

  a_nack_release: assert property (@(negedge LINK_SCL) disable iff (!RST_N)
    st_q == ST_MACK && sda_r_q && !start |=> st_q == ST_IDLE && !oe_q)
    else $error("data driven after master not-acknowledge");

  a_byte_len: assert property (@(negedge LINK_SCL) disable iff (!RST_N)
    $rose(st_q == ST_SEND) |-> (st_q == ST_SEND)[*8] ##1 st_q == ST_MACK)
    else $error("data byte not eight clocks long");

  a_array_ones: assert property (@(negedge LINK_SCL) disable iff (!RST_N)
    st_q == ST_DEV_ACK && rd_q && !sn_q && !start
    |=> !oe_q && tx_q == {ERASED_BYTE[6:0], 1'b0})
    else $error("array byte not all ones");

endmodule : eeprom_read_engine

`default_nettype wire

// ---- tb/link_master.sv ----
/*
  Two-wire bus master model: drives the serial clock and pulls data low.
  Assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none

module link_master (
  output var  logic scl,
  output var  logic pull,
  input  wire logic sda
);
  // ==========================================================
  // timing; clock stands still between frames
  localparam int Q = 16;
  logic [7:0] got_val;
  event       got;

  initial
  begin
    scl  = 1'b1;
    pull = 1'b0;
  end

  task automatic warm;
    repeat (2)
    begin
      scl = 1'b0;
      #(2*Q);
      scl = 1'b1;
      #(2*Q);
    end
  endtask : warm

  // ==========================================================
  // framing; start also serves as repeated start
  task automatic start;
    pull = 1'b0;
    #(Q);
    scl  = 1'b1;
    #(Q);
    pull = 1'b1;
    #(Q);
    scl  = 1'b0;
    #(Q);
  endtask : start

  task automatic stop;
    pull = 1'b1;
    #(Q);
    scl  = 1'b1;
    #(Q);
    pull = 1'b0;
    #(Q);
  endtask : stop

  task automatic put_bit(input logic b);
    pull = ~b;
    #(Q);
    scl  = 1'b1;
    #(2*Q);
    scl  = 1'b0;
    #(Q);
  endtask : put_bit

  task automatic get_bit(output logic b);
    pull = 1'b0;
    #(Q);
    scl  = 1'b1;
    #(Q);
    b    = sda;
    #(Q);
    scl  = 1'b0;
    #(Q);
  endtask : get_bit

  // ==========================================================
  // bytes, msb first; each result is reported by event
  task automatic put_byte(input logic [7:0] b);
    logic a;
    for (int i = 7; i >= 0; i--)
      put_bit(b[i]);
    get_bit(a);
    got_val = {7'h00, a};
    -> got;
  endtask : put_byte

  task automatic get_byte(input logic last);
    logic [7:0] v;
    for (int i = 7; i >= 0; i--)
      get_bit(v[i]);
    got_val = v;
    -> got;
    put_bit(last);
  endtask : get_byte
endmodule : link_master

`default_nettype wire

// ---- tb/serial_eeprom_read_engine_bench.sv ----
/*
  Self-checking bench for the read engine with a master model on the link.
  Assumes the package constants and an open-drain wire with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_read_engine_bench;
  import eeprom_read_pkg::*;
  logic       CLK, RST_N, WRITE_BUSY, SDA_O, SDA_OE, BYTE_SENT, READ_ACTIVE;
  logic       scl, pull, sda;
  logic [2:0] cs_q;
  logic [7:0] wa;
  logic [7:0] q[$];
  logic [3:0] bad[3] = '{4'h9, 4'hc, 4'he};
  int         failures, compares, sent, nbytes, cycles, seed, active;

  // ==========================================================
  // clocks, wire and parts
  always #50 CLK = ~CLK;
  assign sda = !((SDA_OE && !SDA_O) || pull);

  eeprom_read_engine dut (
    .CLK(CLK), .RST_N(RST_N), .CLK_EN(1'b1), .LINK_SCL(scl), .SDA_I(sda),
    .SDA_O(SDA_O), .SDA_OE(SDA_OE), .CHIP_SELECT_BIT_2(cs_q[2]),
    .CHIP_SELECT_BIT_1(cs_q[1]), .CHIP_SELECT_BIT_0(cs_q[0]),
    .WRITE_BUSY(WRITE_BUSY), .BYTE_SENT(BYTE_SENT), .READ_ACTIVE(READ_ACTIVE)
  );
  link_master m (.scl(scl), .pull(pull), .sda(sda));

  // ==========================================================
  // checking
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  always @(m.got) check(m.got_val, q.pop_front());

  always @(posedge CLK)
  begin
    cycles++;
    if (BYTE_SENT === 1'b1)
      sent++;
    if (READ_ACTIVE === 1'b1)
      active++;
    if (cycles == 20000)
    begin
      failures++;
      give_verdict();
    end
  end

  function automatic logic [7:0] sn_byte(input int i);
    return SN_VALUE[127 - 8 * (i % 16) -: 8];
  endfunction : sn_byte

  // ==========================================================
  // transfers
  task automatic dev(input logic [3:0] t, input logic [2:0] c, input logic r,
                     input logic [7:0] a);
    dev_addr_type d;
    d = '{type_code: t, cs: c, rd: r};
    q.push_back(a);
    m.put_byte(d);
  endtask : dev

  task automatic dummy(input logic [3:0] t, input logic [7:0] a);
    m.start();
    dev(t, cs_q, 1'b0, 8'h00);
    q.push_back(8'h00);
    m.put_byte(a);
  endtask : dummy

  task automatic read_seq(input logic [3:0] t, input int n, input int idx,
                          input logic tail);
    m.start();
    dev(t, cs_q, 1'b1, 8'h00);
    for (int i = 0; i < n; i++)
    begin
      q.push_back(t == TYPE_SN ? sn_byte(idx + i) : ERASED_BYTE);
      m.get_byte(i == n - 1);
    end
    nbytes += n;
    if (tail)
    begin
      q.push_back(8'hff);
      m.get_byte(1'b1);
    end
    m.stop();
  endtask : read_seq

  task automatic refuse(input logic [3:0] t, input logic [2:0] c);
    m.start();
    dev(t, c, 1'b1, 8'h01);
    m.stop();
  endtask : refuse

  // ==========================================================
  // main sequence
  initial
  begin
    CLK        = 1'b0;
    RST_N      = 1'b0;
    WRITE_BUSY = 1'b0;
    cs_q       = 3'h0;
    seed       = 32'h87e69a95;
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    m.warm();
    read_seq(TYPE_ARRAY, 1, 0, 1'b0);
    read_seq(TYPE_SN, 1, 1, 1'b1);
    dummy(TYPE_ARRAY, 8'hfe);
    read_seq(TYPE_ARRAY, 3, 0, 1'b0);
    read_seq(TYPE_SN, 1, 1, 1'b0);
    dummy(TYPE_SN, 8'h80);
    read_seq(TYPE_SN, 18, 0, 1'b0);
    repeat (4)
    begin
      @(posedge CLK);
      cs_q <= 3'($random(seed));
      wa   = 8'($random(seed));
      dummy(TYPE_SN, {SN_TOP_BITS, wa[5:0]});
      read_seq(TYPE_SN, 2, int'(wa[3:0]), 1'b0);
      dummy(TYPE_ARRAY, wa);
      read_seq(TYPE_ARRAY, 1, 0, 1'b0);
    end
    foreach (bad[i])
      refuse(bad[i], cs_q);
    refuse(TYPE_ARRAY, ~cs_q);
    @(posedge CLK);
    WRITE_BUSY <= 1'b1;
    refuse(TYPE_ARRAY, cs_q);
    @(posedge CLK);
    WRITE_BUSY <= 1'b0;
    @(posedge CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    m.warm();
    read_seq(TYPE_SN, 1, 0, 1'b0);
    repeat (10) @(posedge CLK);
    check(8'(sent), 8'(nbytes));
    check(8'(active > 0), 8'h01);
    check({7'h00, READ_ACTIVE}, 8'h00);
    check(8'(q.size()), 8'h00);
    give_verdict();
  end
endmodule : serial_eeprom_read_engine_bench

`default_nettype wire
